// [core/supply_trip_detector.sv]
`timescale 1ns/1ps
module supply_trip_detector
  import supply_trip_pkg::*;
#(
  parameter int SETTLE_TICKS = SETTLE_TICK_COUNT
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic comparator_above,
  input wire logic settle_tick_pin,
  input wire logic brownout_enable,
  input wire logic sleep_mode,
  output logic detector_power,
  output logic reference_enable,
  output logic [3:0] trip_level_select,
  output logic external_trip_input_select,
  output logic trip_interrupt_request,
  output logic trip_interrupt_priority,
  output logic wake_request,
  output logic wake_to_vector,
  output logic [7:0] port_a_direction
);

  settle_if settle ();

  ref_settle_timer #(
    .SETTLE_TICKS(SETTLE_TICKS)
  ) u_settle (
    .clock(clock),
    .reset(reset),
    .link(settle.timer)
  );

  logic direction_select_reg;
  logic detector_enable_reg;
  logic [3:0] trip_level_reg;
  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  logic [7:0] enable_two_reg;
  logic [7:0] priority_two_reg;
  logic [7:0] core_intc_reg;
  logic [7:0] port_a_dir_reg;
  logic [7:0] rdata_reg;
  logic [7:0] read_value;
  logic cmp_meta_reg;
  logic cmp_sync_reg;
  logic tick_meta_reg;
  logic tick_sync_reg;
  logic tick_last_reg;
  logic wake_reg;
  logic vector_reg;
  logic trip_seen;
  logic trip_set;
  logic wr_control;
  logic wr_flags;
  logic reference_stable;

  assign wr_control = reg_write && (reg_addr == ADDR_DETECTOR_CONTROL);
  assign wr_flags = reg_write && (reg_addr == ADDR_PERIPHERAL_FLAGS_TWO);

  // async comparator output, first stage read only by the second
  always_ff @(posedge clock) begin
    if (reset) begin
      cmp_meta_reg <= 1'b0;
      cmp_sync_reg <= 1'b0;
    end else begin
      cmp_meta_reg <= comparator_above;
      cmp_sync_reg <= cmp_meta_reg;
    end
  end

  // fixed-time tick from its own oscillator, turned into one-cycle pulses
  always_ff @(posedge clock) begin
    if (reset) begin
      tick_meta_reg <= 1'b0;
      tick_sync_reg <= 1'b0;
      tick_last_reg <= 1'b0;
    end else begin
      tick_meta_reg <= settle_tick_pin;
      tick_sync_reg <= tick_meta_reg;
      tick_last_reg <= tick_sync_reg;
    end
  end

  // reference shared with brown-out reset
  assign settle.ref_on = detector_enable_reg || brownout_enable;
  assign settle.tick = tick_sync_reg && !tick_last_reg;
  assign reference_stable = settle.stable && detector_enable_reg;

  // control register
  always_ff @(posedge clock) begin
    if (reset) begin
      direction_select_reg <= DETECTOR_CONTROL_RESET[DIRECTION_SELECT_BIT];
      detector_enable_reg <= DETECTOR_CONTROL_RESET[DETECTOR_ENABLE_BIT];
      trip_level_reg <= DETECTOR_CONTROL_RESET[TRIP_LEVEL_MSB:TRIP_LEVEL_LSB];
    end else if (wr_control) begin
      direction_select_reg <= reg_wdata[DIRECTION_SELECT_BIT];
      detector_enable_reg <= reg_wdata[DETECTOR_ENABLE_BIT];
      trip_level_reg <= reg_wdata[TRIP_LEVEL_MSB:TRIP_LEVEL_LSB];
    end
  end

  // trip qualification: powered, settled, and in the chosen direction
  always_comb begin
    trip_seen = direction_select_reg ? cmp_sync_reg : !cmp_sync_reg;
    trip_set = detector_enable_reg && settle.stable && trip_seen;
  end

  // peripheral flag register, hardware set wins over a write of zero
  always_comb begin
    flags_next = wr_flags ? reg_wdata : flags_reg;
    if (trip_set) begin
      flags_next[TRIP_FLAG_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      flags_reg <= PERIPHERAL_FLAGS_TWO_RESET;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // interrupt enables, priority, global control and port A direction, plain storage
  always_ff @(posedge clock) begin
    if (reset) begin
      enable_two_reg <= PERIPHERAL_ENABLE_TWO_RESET;
      priority_two_reg <= PERIPHERAL_PRIORITY_TWO_RESET;
      core_intc_reg <= CORE_INTERRUPT_CONTROL_RESET;
      port_a_dir_reg <= PORT_A_DIRECTION_RESET;
    end else if (reg_write) begin
      unique case (reg_addr)
        ADDR_PERIPHERAL_ENABLE_TWO: enable_two_reg <= reg_wdata;
        ADDR_PERIPHERAL_PRIORITY_TWO: priority_two_reg <= reg_wdata;
        ADDR_CORE_INTERRUPT_CONTROL: core_intc_reg <= reg_wdata;
        ADDR_PORT_A_DIRECTION: port_a_dir_reg <= reg_wdata;
        default: ;
      endcase
    end
  end

  // logic keeps running in sleep; a trip there raises wake_request a cycle later, held while the trip lasts
  always_ff @(posedge clock) begin
    if (reset) begin
      wake_reg <= 1'b0;
      vector_reg <= 1'b0;
    end else begin
      wake_reg <= sleep_mode && trip_set;
      vector_reg <= sleep_mode && trip_set
        && core_intc_reg[GLOBAL_INTERRUPT_ENABLE_BIT];
    end
  end

  // read path, data only in the cycle after the strobe
  always_comb begin
    unique case (reg_addr)
      ADDR_DETECTOR_CONTROL: read_value = {direction_select_reg, settle.stable,
        reference_stable, detector_enable_reg, trip_level_reg};
      ADDR_PERIPHERAL_FLAGS_TWO: read_value = flags_reg;
      ADDR_PERIPHERAL_ENABLE_TWO: read_value = enable_two_reg;
      ADDR_PERIPHERAL_PRIORITY_TWO: read_value = priority_two_reg;
      ADDR_CORE_INTERRUPT_CONTROL: read_value = core_intc_reg;
      ADDR_PORT_A_DIRECTION: read_value = port_a_dir_reg;
      default: read_value = 8'h00;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= reg_read ? read_value : 8'h00;
    end
  end

  assign reg_rdata = rdata_reg;
  assign detector_power = detector_enable_reg;
  assign reference_enable = settle.ref_on;
  assign trip_level_select = trip_level_reg;
  assign external_trip_input_select = (trip_level_reg == TRIP_LEVEL_EXTERNAL);
  assign trip_interrupt_request = flags_reg[TRIP_FLAG_BIT]
    && enable_two_reg[TRIP_INTERRUPT_ENABLE_BIT]
    && core_intc_reg[GLOBAL_INTERRUPT_ENABLE_BIT];
  assign trip_interrupt_priority = priority_two_reg[TRIP_INTERRUPT_PRIORITY_BIT];
  assign wake_request = wake_reg;
  assign wake_to_vector = vector_reg;
  assign port_a_direction = port_a_dir_reg;

  a_trip_sets_flag:
  assert property (@(posedge clock) disable iff (reset)
    detector_enable_reg && settle.stable && direction_select_reg && cmp_sync_reg
    |=> flags_reg[TRIP_FLAG_BIT])
  else $error("rising trip did not set flag");

  a_level_written:
  assert property (@(posedge clock) disable iff (reset)
    wr_control |=> trip_level_select == $past(reg_wdata[3:0]))
  else $error("trip level not taken from write");

  a_external_select:
  assert property (@(posedge clock) disable iff (reset)
    wr_control && reg_wdata[3:0] == 4'hF |=> external_trip_input_select)
  else $error("external input not selected");

  a_falling_detect:
  assert property (@(posedge clock) disable iff (reset)
    detector_enable_reg && settle.stable && !direction_select_reg && !cmp_sync_reg
    |=> flags_reg[TRIP_FLAG_BIT])
  else $error("falling trip did not set flag");

  a_no_flag_unstable:
  assert property (@(posedge clock) disable iff (reset)
    !settle.stable && !flags_reg[TRIP_FLAG_BIT] && !wr_flags
    |=> !flags_reg[TRIP_FLAG_BIT])
  else $error("flag set before reference stable");

  a_disabled_quiet:
  assert property (@(posedge clock) disable iff (reset)
    wr_control && !reg_wdata[4] ##1 !flags_reg[TRIP_FLAG_BIT] && !reg_write
    |=> !detector_power && !flags_reg[TRIP_FLAG_BIT])
  else $error("disabled detector powered or tripped");

  a_sync_two_stage:
  assert property (@(posedge clock) disable iff (reset)
    ##2 1'b1 |-> cmp_sync_reg == $past(comparator_above, 2))
  else $error("comparator not delayed by two flops");

  a_set_beats_clear:
  assert property (@(posedge clock) disable iff (reset)
    trip_set && wr_flags && !reg_wdata[2] |=> flags_reg[TRIP_FLAG_BIT])
  else $error("clear beat simultaneous trip");

  a_flag_sticky:
  assert property (@(posedge clock) disable iff (reset)
    flags_reg[TRIP_FLAG_BIT] && !wr_flags |=> flags_reg[TRIP_FLAG_BIT])
  else $error("trip flag dropped without a write");

  a_sleep_wake:
  assert property (@(posedge clock) disable iff (reset)
    sleep_mode && trip_set |=> wake_request && flags_reg[TRIP_FLAG_BIT])
  else $error("sleep trip did not wake");

  a_vector_gated:
  assert property (@(posedge clock) disable iff (reset)
    wake_request |-> wake_to_vector == $past(core_intc_reg[7]))
  else $error("vector not gated by global enable");

  a_reset_control:
  assert property (@(posedge clock)
    reset |=> !detector_power && trip_level_select == 4'h5 && reg_rdata == 8'h00)
  else $error("control register not at reset state");

  a_no_wake_unstable:
  assert property (@(posedge clock) disable iff (reset)
    !settle.stable |=> !wake_request && !wake_to_vector)
  else $error("wake or vector before reference stable");

  a_off_no_trip:
  assert property (@(posedge clock) disable iff (reset)
    !detector_enable_reg && !flags_reg[TRIP_FLAG_BIT] && !wr_flags
    |=> !flags_reg[TRIP_FLAG_BIT])
  else $error("disabled detector set the flag");

  a_divider_select:
  assert property (@(posedge clock) disable iff (reset)
    wr_control && reg_wdata[3:0] != TRIP_LEVEL_EXTERNAL |=> !external_trip_input_select)
  else $error("external input selected for a divider level");

  a_enable_bit:
  assert property (@(posedge clock) disable iff (reset)
    wr_control |=> detector_power == $past(reg_wdata[DETECTOR_ENABLE_BIT]))
  else $error("detector enable not taken from bit four");

  a_stable_readback:
  assert property (@(posedge clock) disable iff (reset)
    reg_read && reg_addr == ADDR_DETECTOR_CONTROL
    |=> reg_rdata[REFERENCE_STABLE_BIT] == ($past(settle.stable) && $past(detector_enable_reg)))
  else $error("reference stable bit reads wrong");

  a_shared_ref_hold:
  assert property (@(posedge clock) disable iff (reset)
    settle.ref_on && settle.stable |=> settle.stable)
  else $error("settling restarted while reference in use");

  a_reset_flags:
  assert property (@(posedge clock)
    reset |=> flags_reg == PERIPHERAL_FLAGS_TWO_RESET && !wake_request)
  else $error("flags or wake not cleared by reset");

endmodule // supply_trip_detector

// [core/supply_trip_pkg.sv]
package supply_trip_pkg;

  // register indices on the byte-wide special-function port
  localparam logic [2:0] ADDR_DETECTOR_CONTROL = 3'h0;
  localparam logic [2:0] ADDR_PERIPHERAL_FLAGS_TWO = 3'h1;
  localparam logic [2:0] ADDR_PERIPHERAL_ENABLE_TWO = 3'h2;
  localparam logic [2:0] ADDR_PERIPHERAL_PRIORITY_TWO = 3'h3;
  localparam logic [2:0] ADDR_CORE_INTERRUPT_CONTROL = 3'h4;
  localparam logic [2:0] ADDR_PORT_A_DIRECTION = 3'h5;

  // detector_control fields
  localparam int DIRECTION_SELECT_BIT = 7;
  localparam int BANDGAP_STABLE_BIT = 6;
  localparam int REFERENCE_STABLE_BIT = 5;
  localparam int DETECTOR_ENABLE_BIT = 4;
  localparam int TRIP_LEVEL_MSB = 3;
  localparam int TRIP_LEVEL_LSB = 0;
  localparam int TRIP_LEVEL_WIDTH = 4;

  // interrupt register fields
  localparam int TRIP_FLAG_BIT = 2;
  localparam int TRIP_INTERRUPT_ENABLE_BIT = 2;
  localparam int TRIP_INTERRUPT_PRIORITY_BIT = 2;
  localparam int GLOBAL_INTERRUPT_ENABLE_BIT = 7;

  localparam logic [3:0] TRIP_LEVEL_EXTERNAL = 4'hF;

  // reset values
  localparam logic [7:0] DETECTOR_CONTROL_RESET = 8'h05;
  localparam logic [7:0] PERIPHERAL_FLAGS_TWO_RESET = 8'h00;
  localparam logic [7:0] PERIPHERAL_ENABLE_TWO_RESET = 8'h00;
  localparam logic [7:0] PERIPHERAL_PRIORITY_TWO_RESET = 8'h00;
  localparam logic [7:0] CORE_INTERRUPT_CONTROL_RESET = 8'h00;
  localparam logic [7:0] PORT_A_DIRECTION_RESET = 8'h00;

  // reference settling, counted on the fixed-time tick, not the system clock
  localparam int REFERENCE_SETTLE_TIME_NS = 20000;
  localparam int SETTLE_TICK_PERIOD_NS = 1000;
  localparam int SETTLE_TICK_COUNT =
    (REFERENCE_SETTLE_TIME_NS + SETTLE_TICK_PERIOD_NS - 1) / SETTLE_TICK_PERIOD_NS;

endpackage

// [core/settle_if.sv]
`timescale 1ns/1ps
interface settle_if;
  logic ref_on;
  logic tick;
  logic stable;
  modport timer (input ref_on, input tick, output stable);
  modport user (output ref_on, output tick, input stable);
endinterface

// [core/ref_settle_timer.sv]
`timescale 1ns/1ps
module ref_settle_timer
  import supply_trip_pkg::*;
#(
  parameter int SETTLE_TICKS = SETTLE_TICK_COUNT
) (
  input wire logic clock,
  input wire logic reset,
  settle_if.timer link
);

  localparam int CW = $clog2(SETTLE_TICKS + 1);

  generate
    if (SETTLE_TICKS < 1) begin : g_bad_ticks
      $error("settle tick count must be at least one");
    end
  endgenerate

  logic [CW-1:0] count_reg;
  logic stable_reg;

  // restarts only once every user has let the reference go
  always_ff @(posedge clock) begin
    if (reset || !link.ref_on) begin
      count_reg <= '0;
      stable_reg <= 1'b0;
    end else if (!stable_reg && link.tick) begin
      count_reg <= count_reg + 1'b1;
      if (count_reg == CW'(SETTLE_TICKS - 1)) begin
        stable_reg <= 1'b1;
      end
    end
  end

  assign link.stable = stable_reg;

  a_settle_after_ticks:
  assert property (@(posedge clock) disable iff (reset)
    $rose(stable_reg) |-> count_reg == CW'(SETTLE_TICKS))
  else $error("reference stable before full settle count");

  a_settle_restart:
  assert property (@(posedge clock) disable iff (reset)
    !link.ref_on |=> !stable_reg && count_reg == '0)
  else $error("settle state kept while reference off");

endmodule // ref_settle_timer

// [tb/supply_comparator_model.sv]
`timescale 1ns/1ps
module supply_comparator_model (
  input wire logic clock,
  input wire logic detector_power,
  input wire logic [3:0] trip_level_select,
  input wire logic external_trip_input_select,
  input wire logic [3:0] supply_level,
  input wire logic external_above,
  output logic comparator_above,
  output logic settle_tick_pin
);
  logic junk_reg = 1'b0;
  logic above;

  initial begin
    settle_tick_pin = 1'b0;
    #7.3;
    // free-running timebase, unrelated to the system clock
    forever #500 settle_tick_pin = ~settle_tick_pin;
  end

  always @(posedge clock) begin
    junk_reg <= ~junk_reg;
  end

  // all-ones level takes the external pin instead of the divider
  assign above = external_trip_input_select ? external_above
    : (supply_level >= trip_level_select);

  // unpowered comparator output is meaningless, so it toggles
  assign #3.7 comparator_above = detector_power ? above : junk_reg;
endmodule // supply_comparator_model

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench;
  import supply_trip_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic brownout_enable = 1'b0;
  logic sleep_mode = 1'b0;
  logic [3:0] supply_level = 4'h8;
  logic external_above = 1'b0;
  logic [7:0] reg_rdata;
  logic comparator_above, settle_tick_pin, detector_power, reference_enable;
  logic external_trip_input_select, trip_interrupt_request, trip_interrupt_priority;
  logic wake_request, wake_to_vector;
  logic [3:0] trip_level_select;
  logic [7:0] port_a_direction;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;

  always #12.5 clock = ~clock;

  supply_trip_detector #(.SETTLE_TICKS(2)) dut (.clock(clock), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .comparator_above(comparator_above),
    .settle_tick_pin(settle_tick_pin), .brownout_enable(brownout_enable),
    .sleep_mode(sleep_mode), .detector_power(detector_power),
    .reference_enable(reference_enable), .trip_level_select(trip_level_select),
    .external_trip_input_select(external_trip_input_select),
    .trip_interrupt_request(trip_interrupt_request),
    .trip_interrupt_priority(trip_interrupt_priority), .wake_request(wake_request),
    .wake_to_vector(wake_to_vector), .port_a_direction(port_a_direction));

  supply_comparator_model partner (.clock(clock), .detector_power(detector_power),
    .trip_level_select(trip_level_select),
    .external_trip_input_select(external_trip_input_select),
    .supply_level(supply_level), .external_above(external_above),
    .comparator_above(comparator_above), .settle_tick_pin(settle_tick_pin));

  task automatic stop_test;
    $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    check("reg_rdata", reg_rdata, exp);
  endtask

  task automatic wake_case(input logic vector_exp);
    logic seen;
    seen = 1'b0;
    supply_level <= 4'h8;
    for (int k = 0; k < 50 && !seen; k++) begin
      @(posedge clock);
      #1;
      seen = (wake_request === 1'b1);
    end
    check("wake_request", seen, 1'b1);
    check("wake_to_vector", wake_to_vector, vector_exp);
  endtask

  initial begin
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    rd(ADDR_DETECTOR_CONTROL, DETECTOR_CONTROL_RESET);
    for (int a = 1; a < 8; a++) begin
      rd(a[2:0], 8'h00);
    end
    check("detector_power", detector_power, 1'b0);
    wr(ADDR_PORT_A_DIRECTION, 8'hA5);
    check("port_a_direction", port_a_direction, 8'hA5);
    wr(3'h6, 8'hFF);
    rd(3'h6, 8'h00);
    wr(ADDR_PERIPHERAL_PRIORITY_TWO, 8'h04);
    check("trip_interrupt_priority", trip_interrupt_priority, 1'b1);
    for (int i = 0; i < 16; i++) begin
      wr(ADDR_DETECTOR_CONTROL, 8'(i));
      check("trip_level_select", trip_level_select, 8'(i));
      check("external_select", external_trip_input_select, i == 15);
    end
    // disabled detector ignores a toggling comparator
    wr(ADDR_DETECTOR_CONTROL, 8'h64);
    rd(ADDR_DETECTOR_CONTROL, 8'h04);
    repeat (100) @(posedge clock);
    rd(ADDR_PERIPHERAL_FLAGS_TWO, 8'h00);
    // falling detection, supply below level 4 from the start
    supply_level <= 4'h2;
    wr(ADDR_DETECTOR_CONTROL, 8'h14);
    check("detector_power", detector_power, 1'b1);
    check("reference_enable", reference_enable, 1'b1);
    rd(ADDR_DETECTOR_CONTROL, 8'h14);
    rd(ADDR_PERIPHERAL_FLAGS_TWO, 8'h00);
    wr(ADDR_PERIPHERAL_ENABLE_TWO, 8'h04);
    wr(ADDR_CORE_INTERRUPT_CONTROL, 8'h80);
    check("irq", trip_interrupt_request, 1'b0);
    repeat (200) @(posedge clock);
    rd(ADDR_DETECTOR_CONTROL, 8'h74);
    rd(ADDR_PERIPHERAL_FLAGS_TWO, 8'h04);
    check("irq", trip_interrupt_request, 1'b1);
    wr(ADDR_PERIPHERAL_FLAGS_TWO, 8'h00);
    rd(ADDR_PERIPHERAL_FLAGS_TWO, 8'h04);
    supply_level <= 4'h8;
    repeat (5) @(posedge clock);
    wr(ADDR_PERIPHERAL_FLAGS_TWO, 8'h00);
    rd(ADDR_PERIPHERAL_FLAGS_TWO, 8'h00);
    check("irq", trip_interrupt_request, 1'b0);
    // rising detection, disabled while changing settings
    supply_level <= 4'h2;
    wr(ADDR_DETECTOR_CONTROL, 8'h04);
    wr(ADDR_DETECTOR_CONTROL, 8'h84);
    wr(ADDR_DETECTOR_CONTROL, 8'h94);
    repeat (200) @(posedge clock);
    wr(ADDR_PERIPHERAL_FLAGS_TWO, 8'h00);
    rd(ADDR_PERIPHERAL_FLAGS_TWO, 8'h00);
    supply_level <= 4'h8;
    repeat (5) @(posedge clock);
    rd(ADDR_PERIPHERAL_FLAGS_TWO, 8'h04);
    // trip in sleep, with and without the global enable
    supply_level <= 4'h2;
    sleep_mode <= 1'b1;
    wr(ADDR_PERIPHERAL_FLAGS_TWO, 8'h00);
    wake_case(1'b1);
    supply_level <= 4'h2;
    wr(ADDR_CORE_INTERRUPT_CONTROL, 8'h00);
    wr(ADDR_PERIPHERAL_FLAGS_TWO, 8'h00);
    wake_case(1'b0);
    sleep_mode <= 1'b0;
    // shared reference: brown-out user keeps it settled
    brownout_enable <= 1'b1;
    wr(ADDR_DETECTOR_CONTROL, 8'h84);
    check("reference_enable", reference_enable, 1'b1);
    wr(ADDR_DETECTOR_CONTROL, 8'h94);
    rd(ADDR_DETECTOR_CONTROL, 8'hF4);
    brownout_enable <= 1'b0;
    wr(ADDR_DETECTOR_CONTROL, 8'h84);
    check("reference_enable", reference_enable, 1'b0);
    wr(ADDR_DETECTOR_CONTROL, 8'h94);
    rd(ADDR_DETECTOR_CONTROL, 8'h94);
    // external pin in place of the divider, supply at the top tap
    supply_level <= 4'hF;
    wr(ADDR_DETECTOR_CONTROL, 8'h84);
    wr(ADDR_DETECTOR_CONTROL, 8'h9F);
    check("external_select", external_trip_input_select, 1'b1);
    repeat (200) @(posedge clock);
    wr(ADDR_PERIPHERAL_FLAGS_TWO, 8'h00);
    rd(ADDR_PERIPHERAL_FLAGS_TWO, 8'h00);
    external_above <= 1'b1;
    repeat (5) @(posedge clock);
    rd(ADDR_PERIPHERAL_FLAGS_TWO, 8'h04);
    // reset in mid-run
    @(posedge clock);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    rd(ADDR_DETECTOR_CONTROL, DETECTOR_CONTROL_RESET);
    rd(ADDR_PERIPHERAL_FLAGS_TWO, 8'h00);
    check("detector_power", detector_power, 1'b0);
    stop_test();
  end
endmodule // testbench
